// ---- verilog/serial_unit_defs.svh ----
// Offsets, field positions, reset values and timing counts of the serial unit
// Assumes inclusion by bare name from the package and the design modules
`ifndef SERIAL_UNIT_DEFS_SVH
`define SERIAL_UNIT_DEFS_SVH

// Register offsets on the plain register port
`define ADDR_W            4
`define OFF_FORMAT        4'h0
`define OFF_CONTROL       4'h1
`define OFF_STATUS        4'h2
`define OFF_TX_HOLD       4'h3
`define OFF_RX_HOLD       4'h4
`define OFF_BAUD          4'h5
`define OFF_IRQ_STAT      4'h6
`define OFF_IRQ_MASK      4'h7

// Status register fields
`define ST_TX_EMPTY       7
`define ST_RX_FULL        6
`define ST_OVERRUN        5
`define ST_FRAMING        4
`define ST_PARITY         3
`define ST_TX_END         2
`define ST_TX_EMPTY_RST   1'b1
`define ST_RX_FULL_RST    1'b0

// Format register fields
`define FMT_CHR7          6
`define FMT_PAR_EN        5
`define FMT_PAR_ODD       4
`define FMT_STOP2         3
`define FMT_RST           8'h00

// Control register fields
`define CTL_TX_ON         5
`define CTL_RX_ON         4
`define CTL_RX_IE         6
`define CTL_RST           8'h00

// Interrupt status bits: 0 rx full, 1 tx empty, 2 overrun, 3 framing, 4 parity
`define IRQ_W             5
`define IRQ_RST           5'h00

// Bit timing: 16 samples per bit, divider from the baud register
`define OVS               16
`define OVS_MID           4'h7
`define OVS_LAST          4'hF
`define BAUD_RST          8'h0A

`endif

// ---- verilog/serial_unit_pkg.sv ----
// Types shared by the serial unit modules
// Assumes the constants header is on the include path
package serial_unit_pkg;
	`include "serial_unit_defs.svh"

	typedef logic [7:0] byte_t;

	typedef struct packed {
		logic data7;
		logic par_en;
		logic par_odd;
		logic stop2;
	} frame_fmt_t;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_START,
		LS_DATA,
		LS_PARITY,
		LS_STOP
	} line_state_t;
endpackage : serial_unit_pkg

// ---- verilog/frame_if.sv ----
// Carries the frame format and sample tick between the top and its shifters
// Assumes one clock domain; all signals are driven by the top
`timescale 1ns/1ns
interface frame_if;
	import serial_unit_pkg::*;
	frame_fmt_t fmt;
	logic       tick;

	modport src  (output fmt, output tick);
	modport sink (input  fmt, input  tick);
endinterface : frame_if

// ---- verilog/serial_tx_shift.sv ----
// Transmit shifter: start, data, optional parity, one or two stop bits
// Assumes a one-cycle load strobe accepted only while ready is high
`timescale 1ns/1ns
`include "serial_unit_defs.svh"
module serial_tx_shift (
	input  wire logic                  clock,
	input  wire logic                  reset,
	frame_if.sink                      fr,
	input  wire serial_unit_pkg::byte_t load_data,
	input  wire logic                  load,
	output logic                       ready,
	output logic                       tx_line
);
	import serial_unit_pkg::*;

	line_state_t st_r;
	byte_t       tx_shifter_r;
	logic [3:0]  ovs_r;
	logic [2:0]  bit_r;
	logic        par_r;
	logic        stop_r;
	logic        line_r;

	// Bit boundary and last data bit
	wire  bit_end   = fr.tick && (ovs_r == `OVS_LAST);
	wire  [2:0] top = fr.fmt.data7 ? 3'h6 : 3'h7;

	assign ready   = (st_r == LS_IDLE);
	assign tx_line = line_r;

	////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge clock) begin
		if (reset) begin
			st_r         <= LS_IDLE;
			tx_shifter_r <= 8'h00;
			ovs_r        <= 4'h0;
			bit_r        <= 3'h0;
			par_r        <= 1'b0;
			stop_r       <= 1'b0;
			line_r       <= 1'b1;
		end else begin
			if (fr.tick)
				ovs_r <= ovs_r + 4'h1;
			case (st_r)
				LS_IDLE: begin
					line_r <= 1'b1;                     // Mark level idle
					if (load) begin
						tx_shifter_r <= load_data;
						par_r        <= fr.fmt.par_odd;
						ovs_r        <= 4'h0;
						line_r       <= 1'b0;           // Start bit low
						st_r         <= LS_START;
					end
				end
				LS_START: if (bit_end) begin
					bit_r  <= 3'h0;
					line_r <= tx_shifter_r[0];
					par_r  <= par_r ^ tx_shifter_r[0];
					st_r   <= LS_DATA;
				end
				LS_DATA: if (bit_end) begin
					if (bit_r == top) begin
						line_r <= fr.fmt.par_en ? par_r : 1'b1;
						stop_r <= 1'b0;
						st_r   <= fr.fmt.par_en ? LS_PARITY : LS_STOP;
					end else begin
						bit_r  <= bit_r + 3'h1;
						line_r <= tx_shifter_r[bit_r + 3'h1];
						par_r  <= par_r ^ tx_shifter_r[bit_r + 3'h1];
					end
				end
				LS_PARITY: if (bit_end) begin
					line_r <= 1'b1;
					st_r   <= LS_STOP;
				end
				LS_STOP: if (bit_end) begin
					if (fr.fmt.stop2 && !stop_r)
						stop_r <= 1'b1;                 // Second stop bit
					else
						st_r <= LS_IDLE;
				end
				default: st_r <= LS_IDLE;
			endcase
		end
	end
endmodule : serial_tx_shift

// ---- verilog/serial_rx_shift.sv ----
// Receive shifter: start detect, mid-bit sampling, parity and stop check
// Assumes the line input is already synchronised to clock
`timescale 1ns/1ns
`include "serial_unit_defs.svh"
module serial_rx_shift (
	input  wire logic                   clock,
	input  wire logic                   reset,
	frame_if.sink                       fr,
	input  wire logic                   enable,
	input  wire logic                   rx_line,
	output serial_unit_pkg::byte_t      word,
	output logic                        done,
	output logic                        frame_err,
	output logic                        par_err
);
	import serial_unit_pkg::*;

	line_state_t st_r;
	byte_t       rx_shifter_r;
	logic [3:0]  ovs_r;
	logic [2:0]  bit_r;
	logic        par_r;
	logic        stop_r;
	logic        done_r;
	logic        ferr_r;
	logic        perr_r;

	// Sample point at mid bit
	wire  sample    = fr.tick && (ovs_r == `OVS_MID);
	wire  [2:0] top = fr.fmt.data7 ? 3'h6 : 3'h7;

	assign word      = rx_shifter_r;
	assign done      = done_r;
	assign frame_err = ferr_r;
	assign par_err   = perr_r;

	////////////////////////////////////////////////////////////////
	// Reception sequencer
	always_ff @(posedge clock) begin
		if (reset) begin
			st_r <= LS_IDLE;
			rx_shifter_r <= 8'h00;
			ovs_r <= 4'h0;
			bit_r <= 3'h0;
			par_r <= 1'b0;
			stop_r <= 1'b0;
			done_r <= 1'b0;
			ferr_r <= 1'b0;
			perr_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (fr.tick)
				ovs_r <= ovs_r + 4'h1;
			case (st_r)
				LS_IDLE: begin
					ovs_r <= 4'h0;
					if (enable && !rx_line)            // Space level is start
						st_r <= LS_START;
				end
				LS_START: if (sample) begin
					if (rx_line)
						st_r <= LS_IDLE;                // Glitch, not a start
					else begin
						bit_r <= 3'h0;
						par_r <= fr.fmt.par_odd;
						rx_shifter_r <= 8'h00;
						st_r <= LS_DATA;
					end
				end
				LS_DATA: if (sample) begin
					rx_shifter_r[bit_r] <= rx_line;
					par_r <= par_r ^ rx_line;
					if (bit_r == top)
						st_r <= fr.fmt.par_en ? LS_PARITY : LS_STOP;
					else
						bit_r <= bit_r + 3'h1;
				end
				LS_PARITY: if (sample) begin
					perr_r <= par_r ^ rx_line;
					stop_r <= 1'b0;
					st_r <= LS_STOP;
				end
				LS_STOP: if (sample) begin
					ferr_r <= !rx_line;                // Stop must be high
					done_r <= 1'b1;
					st_r <= LS_IDLE;
					if (!fr.fmt.par_en)
						perr_r <= 1'b0;
				end
				default: st_r <= LS_IDLE;
			endcase
		end
	end
endmodule : serial_rx_shift

// ---- verilog/serial_unit.sv ----
// Asynchronous serial transceiver with holding registers and flags
// Assumes a plain register port on clock; rx pin is asynchronous
//
// Behaviour
// - Good reception with overrun flag clear moves word, sets full bit 6
// - Full flag cleared by zero after reading one
// - Transfer controller read of holding clears full
// - Receiver disable leaves full flag unchanged
// - Reception while full flags overrun, loses word
// - Frame: low start, data, parity, high stops
// - Idle high; falling line starts reception
// - Transmitter and receiver run independently
// - Holding plus shift register in each direction
// - Twelve formats: length, parity, stop count
// - Empty flag bit 7 set when disabled/moved
`timescale 1ns/1ns
`include "serial_unit_defs.svh"
module serial_unit (
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic [`ADDR_W-1:0]        addr,
	input  wire serial_unit_pkg::byte_t    wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output serial_unit_pkg::byte_t         rdata,
	input  wire logic                      dma_rx_read,
	input  wire logic                      rx_pin,
	output logic                           tx_pin,
	output logic                           rx_irq,
	output logic                           irq
);
	import serial_unit_pkg::*;

	frame_if fr ();

	byte_t       serial_format_reg_r;
	byte_t       serial_control_reg_r;
	byte_t       baud_r;
	byte_t       tx_holding_word_r;
	byte_t       rx_holding_word_r;
	byte_t       rdata_r;
	logic [7:0]  div_r;
	logic        tx_empty_flag_r;
	logic        rx_full_flag_r;
	logic        overrun_r;
	logic        framing_r;
	logic        parity_r;
	logic        full_seen_r;
	logic        empty_seen_r;
	logic [`IRQ_W-1:0] irq_stat_r;
	logic [`IRQ_W-1:0] irq_mask_r;
	logic        rx_meta_r;
	logic        rx_sync_r;
	logic        tx_busy_d_r;

	logic        tx_ready;
	logic        rx_done;
	logic        rx_ferr;
	logic        rx_perr;
	byte_t       rx_word;

	////////////////////////////////////////////////////////////////
	// Decode
	wire tx_on  = serial_control_reg_r[`CTL_TX_ON];
	wire rx_on  = serial_control_reg_r[`CTL_RX_ON];
	wire rx_ie  = serial_control_reg_r[`CTL_RX_IE];
	wire wr_fmt = wr && (addr == `OFF_FORMAT);
	wire wr_ctl = wr && (addr == `OFF_CONTROL);
	wire wr_st  = wr && (addr == `OFF_STATUS);
	wire wr_txh = wr && (addr == `OFF_TX_HOLD);
	wire wr_bd  = wr && (addr == `OFF_BAUD);
	wire wr_is  = wr && (addr == `OFF_IRQ_STAT);
	wire wr_im  = wr && (addr == `OFF_IRQ_MASK);
	wire rd_st  = rd && (addr == `OFF_STATUS);

	// Load shifter when holding word is waiting
	wire tx_load   = tx_on && !tx_empty_flag_r && tx_ready;
	wire rx_good   = rx_done && !rx_ferr && !rx_perr;
	wire rx_accept = rx_good && !rx_full_flag_r && !overrun_r;
	wire rx_lost   = rx_done && rx_full_flag_r;

	// Flag clears: full and empty need read-one then write-zero, full also on transfer read; error flags clear on write-zero alone
	wire clr_full  = (wr_st && full_seen_r && !wdata[`ST_RX_FULL])
	               || dma_rx_read;
	wire clr_empty = wr_st && empty_seen_r && !wdata[`ST_TX_EMPTY];
	wire clr_ovr   = wr_st && !wdata[`ST_OVERRUN];
	wire clr_fer   = wr_st && !wdata[`ST_FRAMING];
	wire clr_per   = wr_st && !wdata[`ST_PARITY];

	wire [`IRQ_W-1:0] irq_ev = {rx_done && rx_perr, rx_done && rx_ferr,
	                            rx_lost, tx_load, rx_accept};

	wire [7:0] status = {tx_empty_flag_r, rx_full_flag_r, overrun_r,
	                     framing_r, parity_r, tx_ready && tx_empty_flag_r,
	                     2'b00};

	assign fr.fmt.data7   = serial_format_reg_r[`FMT_CHR7];
	assign fr.fmt.par_en  = serial_format_reg_r[`FMT_PAR_EN];
	assign fr.fmt.par_odd = serial_format_reg_r[`FMT_PAR_ODD];
	assign fr.fmt.stop2   = serial_format_reg_r[`FMT_STOP2];
	assign fr.tick        = (div_r == 8'h00);

	assign rx_irq = rx_full_flag_r && rx_ie;
	assign irq    = |(irq_stat_r & irq_mask_r);
	assign rdata  = rdata_r;

	////////////////////////////////////////////////////////////////
	// Pin synchroniser
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end else begin
			rx_meta_r <= rx_pin;
			rx_sync_r <= rx_meta_r;
		end
	end

	// Oversample tick divider
	always_ff @(posedge clock) begin
		if (reset)
			div_r <= `BAUD_RST;
		else if (div_r == 8'h00)
			div_r <= baud_r;
		else
			div_r <= div_r - 8'h01;
	end

	////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge clock) begin
		if (reset) begin
			serial_format_reg_r  <= `FMT_RST;
			serial_control_reg_r <= `CTL_RST;
			baud_r               <= `BAUD_RST;
			irq_mask_r           <= `IRQ_RST;
		end else begin
			if (wr_fmt) serial_format_reg_r <= wdata;
			if (wr_ctl) serial_control_reg_r <= wdata;
			if (wr_bd)  baud_r <= wdata;
			if (wr_im)  irq_mask_r <= wdata[`IRQ_W-1:0];
		end
	end

	// Transmit holding word and empty flag
	always_ff @(posedge clock) begin
		if (reset) begin
			tx_holding_word_r <= 8'h00;
			tx_empty_flag_r   <= `ST_TX_EMPTY_RST;
		end else begin
			if (wr_txh)
				tx_holding_word_r <= wdata;
			if (!tx_on || tx_load)
				tx_empty_flag_r <= 1'b1;
			else if (clr_empty || wr_txh)
				tx_empty_flag_r <= 1'b0;
		end
	end

	// Receive holding word, full flag, errors
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_holding_word_r <= 8'h00;
			rx_full_flag_r    <= `ST_RX_FULL_RST;
			overrun_r         <= 1'b0;
			framing_r         <= 1'b0;
			parity_r          <= 1'b0;
		end else begin
			if (rx_accept)
				rx_holding_word_r <= rx_word;
			// Set wins over clear; rx_on has no effect here
			if (rx_accept)
				rx_full_flag_r <= 1'b1;
			else if (clr_full)
				rx_full_flag_r <= 1'b0;
			if (rx_lost)
				overrun_r <= 1'b1;
			else if (clr_ovr)
				overrun_r <= 1'b0;
			if (rx_done && rx_ferr)
				framing_r <= 1'b1;
			else if (clr_fer)
				framing_r <= 1'b0;
			if (rx_done && rx_perr)
				parity_r <= 1'b1;
			else if (clr_per)
				parity_r <= 1'b0;
		end
	end

	// Remembers flags read as one
	always_ff @(posedge clock) begin
		if (reset) begin
			full_seen_r  <= 1'b0;
			empty_seen_r <= 1'b0;
		end else begin
			if (rd_st)
				full_seen_r <= rx_full_flag_r;
			else if (!rx_full_flag_r)
				full_seen_r <= 1'b0;
			if (rd_st)
				empty_seen_r <= tx_empty_flag_r;
			else if (!tx_empty_flag_r)
				empty_seen_r <= 1'b0;
		end
	end

	// Sticky interrupt status, write one clears, set wins
	always_ff @(posedge clock) begin
		if (reset)
			irq_stat_r <= `IRQ_RST;
		else
			irq_stat_r <= irq_ev | (irq_stat_r & ~(wr_is ? wdata[`IRQ_W-1:0] : 5'h00));
	end

	// Read data, one cycle after strobe
	always_ff @(posedge clock) begin
		if (reset)
			rdata_r <= 8'h00;
		else if (rd)
			case (addr)
				`OFF_FORMAT:   rdata_r <= serial_format_reg_r;
				`OFF_CONTROL:  rdata_r <= serial_control_reg_r;
				`OFF_STATUS:   rdata_r <= status;
				`OFF_TX_HOLD:  rdata_r <= tx_holding_word_r;
				`OFF_RX_HOLD:  rdata_r <= rx_holding_word_r;
				`OFF_BAUD:     rdata_r <= baud_r;
				`OFF_IRQ_STAT: rdata_r <= {3'h0, irq_stat_r};
				`OFF_IRQ_MASK: rdata_r <= {3'h0, irq_mask_r};
				default:       rdata_r <= 8'h00;
			endcase
		else
			rdata_r <= 8'h00;
	end

	// Tracks shifter activity for assertions
	always_ff @(posedge clock) begin
		if (reset)
			tx_busy_d_r <= 1'b0;
		else
			tx_busy_d_r <= !tx_ready;
	end

	////////////////////////////////////////////////////////////////
	// Independent shifters
	serial_tx_shift u_tx (
		.clock     (clock),
		.reset     (reset),
		.fr        (fr.sink),
		.load_data (tx_holding_word_r),
		.load      (tx_load),
		.ready     (tx_ready),
		.tx_line   (tx_pin)
	);

	serial_rx_shift u_rx (
		.clock     (clock),
		.reset     (reset),
		.fr        (fr.sink),
		.enable    (rx_on),
		.rx_line   (rx_sync_r),
		.word      (rx_word),
		.done      (rx_done),
		.frame_err (rx_ferr),
		.par_err   (rx_perr)
	);

	////////////////////////////////////////////////////////////////
	// Assertions
	a_full_set: assert property (@(posedge clock) disable iff (reset)
		rx_accept |=> rx_full_flag_r && rx_holding_word_r == $past(rx_word))
		else $error("full flag or word not loaded");
	a_full_clear: assert property (@(posedge clock) disable iff (reset)
		$fell(rx_full_flag_r) |-> $past(clr_full))
		else $error("full flag cleared without cause");
	a_dma_clear: assert property (@(posedge clock) disable iff (reset)
		dma_rx_read && !rx_accept |=> !rx_full_flag_r)
		else $error("transfer read did not clear full");
	a_rxoff_keep: assert property (@(posedge clock) disable iff (reset)
		wr_ctl && !wdata[`CTL_RX_ON] && !rx_accept && !clr_full
		|=> rx_full_flag_r == $past(rx_full_flag_r))
		else $error("receiver disable changed full flag");
	a_overrun_set: assert property (@(posedge clock) disable iff (reset)
		rx_lost |=> overrun_r && $stable(rx_holding_word_r))
		else $error("overrun not flagged or word overwritten");
	a_overrun_hold: assert property (@(posedge clock) disable iff (reset)
		overrun_r && !clr_ovr |=> overrun_r)
		else $error("overrun flag not sticky");
	a_tx_start: assert property (@(posedge clock) disable iff (reset)
		tx_load |=> !tx_pin)
		else $error("start bit not low");
	a_tx_idle: assert property (@(posedge clock) disable iff (reset)
		tx_ready && !tx_busy_d_r |-> tx_pin)
		else $error("line not idle high");
	a_empty_set: assert property (@(posedge clock) disable iff (reset)
		!tx_on || tx_load |=> tx_empty_flag_r)
		else $error("empty flag not set");
	a_rx_request: assert property (@(posedge clock) disable iff (reset)
		rx_accept && rx_ie && !wr_ctl |=> rx_irq)
		else $error("receive request not raised");
	a_rx_release: assert property (@(posedge clock) disable iff (reset)
		clr_full && !rx_accept |=> !rx_irq)
		else $error("receive request not dropped");

	c_rx_word:  cover property (@(posedge clock) rx_accept);
	c_overrun:  cover property (@(posedge clock) rx_lost);
	c_tx_b2b:   cover property (@(posedge clock) tx_load ##[1:1000] tx_load);
	c_duplex:   cover property (@(posedge clock) !tx_ready && rx_done);
endmodule : serial_unit

// ---- tb/remote_serial.sv ----
// Remote serial device facing the unit: sends frames, decodes the unit output
// Assumes the unit runs 16 clocks per bit and sends 8 data bits
`timescale 1ns/1ns
module remote_serial (
	input  wire logic clock,
	output logic      line_out,
	input  wire logic line_in
);
	import serial_unit_pkg::*;
	localparam int BIT = 16;
	byte_t got_word;
	int    got_count;
	logic  stop_ok;

	////////////////////////////////////////////////////////////////////////////
	// Line rests at mark level
	initial begin
		line_out = 1'b1;
		got_count = 0;
		stop_ok = 1'b0;
	end

	// One frame; bad flips parity, or pulls stop low when parity is off
	task automatic send(input byte_t b, input logic d7, input logic pe,
		input logic po, input logic s2, input logic bad);
		logic par;
		int   n;
		n = d7 ? 7 : 8;
		par = (^(d7 ? {1'b0, b[6:0]} : b)) ^ po ^ bad;
		@(posedge clock);
		line_out <= 1'b0;
		repeat (BIT) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			line_out <= b[i];
			repeat (BIT) @(posedge clock);
		end
		if (pe) begin
			line_out <= par;
			repeat (BIT) @(posedge clock);
		end
		line_out <= !(bad && !pe);
		repeat (s2 ? 2 * BIT : BIT) @(posedge clock);
		line_out <= 1'b1;
	endtask : send

	////////////////////////////////////////////////////////////////////////////
	// Decoder: falling edge, mid-bit samples, LSB first, stop check
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clock);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clock);
				got_word[i] = line_in;
			end
			repeat (BIT) @(posedge clock);
			stop_ok = line_in;
			got_count++;
		end
	end
endmodule : remote_serial

// ---- tb/tb_top.sv ----
// Self-checking bench of the serial unit against a remote serial device
// Assumes the baud register is written 0, so one bit spans 16 clocks
`timescale 1ns/1ns
module tb_top;
	import serial_unit_pkg::*;
	logic       clock;
	logic       reset;
	logic [3:0] addr;
	byte_t      wdata;
	logic       wr;
	logic       rd;
	byte_t      rdata;
	logic       dma_rx_read;
	logic       line_to_dut;
	logic       tx_pin;
	logic       rx_irq;
	logic       irq;
	int         fail_count;
	int         cmp_count;
	int         cycles = 0;
	byte_t      rv;

	serial_unit u_dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .dma_rx_read(dma_rx_read), .rx_pin(line_to_dut),
		.tx_pin(tx_pin), .rx_irq(rx_irq), .irq(irq));
	remote_serial u_peer (.clock(clock), .line_out(line_to_dut), .line_in(tx_pin));

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input string what, input byte_t exp, input byte_t got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input byte_t d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output byte_t d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	task automatic wait_rx;
		int n;
		n = 0;
		while (rx_irq !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		chk("rx_irq wait", 8'h01, {7'h00, rx_irq});
	endtask : wait_rx

	task automatic wait_peer(input int target);
		int n;
		n = 0;
		while (u_peer.got_count < target && n < 400) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_peer

	task automatic clr_full;
		reg_rd(4'h2, rv);
		reg_wr(4'h2, 8'h80);
	endtask : clr_full

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		reg_rd(4'h2, rv);
		chk("status reset", 8'h84, rv);
		@(posedge clock);
		#1 chk("rdata idle", 8'h00, rdata);
		chk("rx_irq reset", 8'h00, {7'h00, rx_irq});
		reg_rd(4'h8, rv);
		chk("unmapped", 8'h00, rv);
		reg_wr(4'h5, 8'h00);
		reg_wr(4'h1, 8'h70);
	endtask : t_reset

	task automatic t_rx_overrun;
		u_peer.send(8'hA5, 0, 0, 0, 0, 0);
		wait_rx();
		reg_rd(4'h4, rv);
		chk("rx word", 8'hA5, rv);
		u_peer.send(8'h3C, 0, 0, 0, 0, 0);
		reg_rd(4'h2, rv);
		chk("overrun", 8'h60, rv & 8'h60);
		reg_rd(4'h4, rv);
		chk("old word", 8'hA5, rv);
		reg_wr(4'h2, 8'h80);
		reg_rd(4'h2, rv);
		chk("cleared", 8'h00, rv & 8'h60);
		chk("rx_irq off", 8'h00, {7'h00, rx_irq});
	endtask : t_rx_overrun

	task automatic t_clear_paths;
		u_peer.send(8'h3C, 0, 0, 0, 0, 0);
		wait_rx();
		reg_wr(4'h2, 8'h80);
		reg_rd(4'h2, rv);
		chk("no read clear", 8'h40, rv & 8'h40);
		reg_wr(4'h1, 8'h60);
		reg_rd(4'h2, rv);
		chk("rx off keeps", 8'h40, rv & 8'h40);
		@(posedge clock);
		dma_rx_read <= 1'b1;
		@(posedge clock);
		dma_rx_read <= 1'b0;
		reg_rd(4'h2, rv);
		chk("dma clear", 8'h00, rv & 8'h40);
		reg_wr(4'h1, 8'h70);
	endtask : t_clear_paths

	task automatic t_irq;
		reg_wr(4'h6, 8'h1F);
		u_peer.send(8'h42, 0, 0, 0, 0, 0);
		wait_rx();
		reg_rd(4'h6, rv);
		chk("irq stat", 8'h01, rv & 8'h01);
		chk("irq masked", 8'h00, {7'h00, irq});
		reg_wr(4'h7, 8'h01);
		#1 chk("irq on", 8'h01, {7'h00, irq});
		reg_wr(4'h6, 8'h01);
		#1 chk("irq cleared", 8'h00, {7'h00, irq});
		reg_wr(4'h7, 8'h00);
		clr_full();
	endtask : t_irq

	task automatic t_tx;
		int n;
		int k;
		n = u_peer.got_count;
		reg_wr(4'h3, 8'h5A);
		wait_peer(n + 1);
		chk("tx word", 8'h5A, u_peer.got_word);
		chk("tx stop", 8'h01, {7'h00, u_peer.stop_ok});
		reg_wr(4'h3, 8'h11);
		k = 0;
		rv = 8'h00;
		while (rv[7] !== 1'b1 && k < 20) begin
			reg_rd(4'h2, rv);
			k++;
		end
		chk("tx empty", 8'h80, rv & 8'h80);
		reg_wr(4'h3, 8'h22);
		reg_rd(4'h2, rv);
		chk("tx held", 8'h00, rv & 8'h80);
		wait_peer(n + 2);
		chk("tx first", 8'h11, u_peer.got_word);
		wait_peer(n + 3);
		chk("tx second", 8'h22, u_peer.got_word);
	endtask : t_tx

	task automatic t_duplex;
		int n;
		n = u_peer.got_count;
		fork
			u_peer.send(8'h77, 0, 0, 0, 0, 0);
			reg_wr(4'h3, 8'h66);
		join
		wait_peer(n + 1);
		chk("duplex tx", 8'h66, u_peer.got_word);
		wait_rx();
		reg_rd(4'h4, rv);
		chk("duplex rx", 8'h77, rv);
		clr_full();
	endtask : t_duplex

	// Parity bit of sent frames lands in the peer's ninth slot
	task automatic t_tx_parity;
		int n;
		n = u_peer.got_count;
		reg_wr(4'h0, 8'h20);
		reg_wr(4'h3, 8'h03);
		wait_peer(n + 1);
		chk("tx even parity", 8'h00, {7'h00, u_peer.stop_ok});
		reg_wr(4'h0, 8'h30);
		reg_wr(4'h3, 8'h03);
		wait_peer(n + 2);
		chk("tx odd parity", 8'h01, {7'h00, u_peer.stop_ok});
		chk("tx parity word", 8'h03, u_peer.got_word);
		reg_wr(4'h0, 8'h00);
	endtask : t_tx_parity

	task automatic t_formats;
		byte_t b;
		byte_t m;
		logic  d7;
		logic  pe;
		logic  po;
		logic  s2;
		for (int i = 0; i < 12; i++) begin
			d7 = i[0];
			s2 = i[1];
			pe = (i >= 4);
			po = (i >= 8);
			b = 8'hC6 ^ byte_t'(i * 17);
			m = d7 ? 8'h7F : 8'hFF;
			reg_wr(4'h0, {1'b0, d7, pe, po, s2, 3'b000});
			u_peer.send(b, d7, pe, po, s2, 0);
			wait_rx();
			reg_rd(4'h4, rv);
			chk("format word", b & m, rv & m);
			clr_full();
			chk("format errors", 8'h00, rv & 8'h38);
		end
	endtask : t_formats

	task automatic t_errors;
		reg_wr(4'h0, 8'h20);
		u_peer.send(8'h5C, 0, 1, 0, 0, 1);
		repeat (8) @(posedge clock);
		reg_rd(4'h2, rv);
		chk("parity err", 8'h08, rv & 8'h48);
		reg_wr(4'h0, 8'h00);
		u_peer.send(8'h5C, 0, 0, 0, 0, 1);
		reg_rd(4'h2, rv);
		chk("framing err", 8'h10, rv & 8'h10);
	endtask : t_errors

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		dma_rx_read = 1'b0;
		fail_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_rx_overrun();
		t_clear_paths();
		t_irq();
		t_tx();
		t_duplex();
		t_tx_parity();
		t_formats();
		t_errors();
		give_verdict();
	end
endmodule : tb_top
